// ### ccu_params.svh
// constants of the capture/compare unit: offsets, codes, reset values
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH
// register byte offsets
`define CCU_OFS_CTRL1 8'h00
`define CCU_OFS_DLO1 8'h04
`define CCU_OFS_DHI1 8'h08
`define CCU_OFS_CTRL2 8'h0C
`define CCU_OFS_DLO2 8'h10
`define CCU_OFS_DHI2 8'h14
`define CCU_OFS_ASSIGN 8'h18
`define CCU_OFS_FLAGS 8'h1C
`define CCU_OFS_IEN 8'h20
`define CCU_OFS_STEP 8'h0C
// mode codes
`define CCU_MODE_OFF 4'h0
`define CCU_MODE_TOGGLE 4'h2
`define CCU_MODE_CAP_FALL 4'h4
`define CCU_MODE_CAP_RISE 4'h5
`define CCU_MODE_CAP_4 4'h6
`define CCU_MODE_CAP_16 4'h7
`define CCU_MODE_SET_HI 4'h8
`define CCU_MODE_SET_LO 4'h9
`define CCU_MODE_SWINT 4'hA
`define CCU_MODE_SPECIAL 4'hB
`define CCU_CAP_PREFIX 2'h1
`define CCU_PWM_PREFIX 2'h3
// prescaler end counts
`define CCU_PS4_LAST 2'h3
`define CCU_PS16_LAST 4'hF
// reset values
`define CCU_CTRL_RST 6'h00
`define CCU_DATA_RST 16'h0000
`define CCU_ASSIGN_RST 2'h0
`define CCU_ASSIGN_SPLIT 2'h1
`define CCU_PS_RST 4'h0
`endif

// ### ccu_pkg.sv
// types shared by the capture/compare unit
package ccu_pkg;
  // control word of one unit
  typedef struct packed {
    logic [1:0] duty;
    logic [3:0] mode;
  } ccu_ctrl_t;
  // what a pad offers to the unit
  typedef struct packed {
    logic level;
    logic dirIn;
    logic ioLatch;
  } ccu_pin_in_t;
  // what the unit drives onto a pad
  typedef struct packed {
    logic drive;
    logic oe;
  } ccu_pin_out_t;
endpackage

// ### ccu_capture_compare_unit.sv
// two capture/compare units with an ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "ccu_params.svh"
module ccu_capture_compare_unit import ccu_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // timers
  input wire logic [15:0] firstTimerCount,
  input wire logic [15:0] thirdTimerCount,
  input wire logic firstTimerWrite,
  input wire logic thirdTimerWrite,
  output logic resetFirstTimer,
  output logic resetThirdTimer,
  output logic adStart,
  // pads
  input wire ccu_pin_in_t unitOnePin,
  input wire ccu_pin_in_t portCPinOne,
  input wire ccu_pin_in_t portBPinThree,
  input wire logic unitTwoPinRoute,
  output ccu_pin_out_t unitOnePinOut,
  output ccu_pin_out_t portCPinOneOut,
  output ccu_pin_out_t portBPinThreeOut,
  // status toward interrupt and pwm logic
  output logic [1:0] unitInterruptFlag,
  output logic [1:0] unitInterruptEnable,
  output logic [1:0] pwmActive,
  output logic [1:0][9:0] pwmDuty
);

  // mode classification
  function automatic logic isCapture(input logic [3:0] m);
    return m[3:2] == `CCU_CAP_PREFIX;
  endfunction
  function automatic logic isPwm(input logic [3:0] m);
    return m[3:2] == `CCU_PWM_PREFIX;
  endfunction
  function automatic logic isCompare(input logic [3:0] m);
    return m == `CCU_MODE_TOGGLE || m == `CCU_MODE_SET_HI ||
      m == `CCU_MODE_SET_LO || m == `CCU_MODE_SWINT ||
      m == `CCU_MODE_SPECIAL;
  endfunction

  ccu_ctrl_t [1:0] ctrl_ff;
  logic [1:0][15:0] data_ff;
  logic [1:0] assign_ff;
  logic [1:0] flag_ff;
  logic [1:0] ien_ff;
  logic wrPend_ff;
  logic [7:0] wrAddr_ff;
  logic [31:0] hrdata_ff;
  logic [1:0] syncA_ff;
  logic [1:0] syncB_ff;
  logic [1:0] prev_ff;
  logic [1:0][3:0] ps_ff;
  logic [1:0] matchPrev_ff;
  logic [1:0] cmpLatch_ff;
  logic resetFirst_ff;
  logic resetThird_ff;
  logic adStart_ff;
  logic [1:0] pwmActive_ff;
  logic [1:0][9:0] pwmDuty_ff;
  logic [1:0] pinLevel;
  logic [1:0] pinDir;
  logic [1:0] pinLatch;
  logic [1:0] useThird;
  logic [1:0][15:0] timebase;
  logic [1:0] riseEdge;
  logic [1:0] fallEdge;
  logic [1:0] capEvent;
  logic [1:0] matchEdge;
  logic [1:0] seReq;
  logic [1:0] ctrlWr;
  logic [1:0] dloWr;
  logic [1:0] dhiWr;
  logic flagWr;
  logic addrPhase;
  logic [31:0] readMux;
  logic [1:0] unitDrives;
  logic [1:0] padOut;

  // zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign addrPhase = hsel & htrans[1] & hready;

  // write data arrives one cycle after its address phase
  always_ff @(posedge mclk) begin
    if (srst) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
    end else begin
      wrPend_ff <= addrPhase & hwrite;
      if (addrPhase & hwrite) begin
        wrAddr_ff <= haddr[7:0];
      end
    end
  end

  // per-unit write strobes, unit two sits one step above unit one
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      ctrlWr[u] = wrPend_ff &&
        wrAddr_ff == `CCU_OFS_CTRL1 + 8'(u) * `CCU_OFS_STEP;
      dloWr[u] = wrPend_ff &&
        wrAddr_ff == `CCU_OFS_DLO1 + 8'(u) * `CCU_OFS_STEP;
      dhiWr[u] = wrPend_ff &&
        wrAddr_ff == `CCU_OFS_DHI1 + 8'(u) * `CCU_OFS_STEP;
    end
  end
  assign flagWr = wrPend_ff && wrAddr_ff == `CCU_OFS_FLAGS;

  // read mux; unmapped offsets read zero
  always_comb begin
    readMux = 32'h00000000;
    unique case (haddr[7:0])
      `CCU_OFS_CTRL1: readMux = {26'h0000000, ctrl_ff[0]};
      `CCU_OFS_DLO1: readMux = {24'h000000, data_ff[0][7:0]};
      `CCU_OFS_DHI1: readMux = {24'h000000, data_ff[0][15:8]};
      `CCU_OFS_CTRL2: readMux = {26'h0000000, ctrl_ff[1]};
      `CCU_OFS_DLO2: readMux = {24'h000000, data_ff[1][7:0]};
      `CCU_OFS_DHI2: readMux = {24'h000000, data_ff[1][15:8]};
      `CCU_OFS_ASSIGN: readMux = {30'h00000000, assign_ff};
      `CCU_OFS_FLAGS: readMux = {30'h00000000, flag_ff};
      `CCU_OFS_IEN: readMux = {30'h00000000, ien_ff};
      default: readMux = 32'h00000000;
    endcase
  end

  // read data is caught at the address phase and stands in the data phase
  always_ff @(posedge mclk) begin
    if (srst) begin
      hrdata_ff <= 32'h00000000;
    end else if (addrPhase & ~hwrite) begin
      hrdata_ff <= readMux;
    end
  end

  // software configuration registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_ff <= {2{`CCU_CTRL_RST}};
      assign_ff <= `CCU_ASSIGN_RST;
      ien_ff <= 2'h0;
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (ctrlWr[u]) begin
          ctrl_ff[u] <= hwdata[5:0];
        end
      end
      if (wrPend_ff && wrAddr_ff == `CCU_OFS_ASSIGN) begin
        assign_ff <= hwdata[1:0];
      end
      if (wrPend_ff && wrAddr_ff == `CCU_OFS_IEN) begin
        ien_ff <= hwdata[1:0];
      end
    end
  end

  // timer choice for capture and compare
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      useThird[u] = assign_ff[1] ||
        (u == 1 && assign_ff == `CCU_ASSIGN_SPLIT);
      timebase[u] = useThird[u] ? thirdTimerCount : firstTimerCount;
    end
  end

  // pad selection; unit two follows the route bit
  always_comb begin
    pinLevel[0] = unitOnePin.level;
    pinDir[0] = unitOnePin.dirIn;
    pinLatch[0] = unitOnePin.ioLatch;
    pinLevel[1] = unitTwoPinRoute ? portCPinOne.level
      : portBPinThree.level;
    pinDir[1] = unitTwoPinRoute ? portCPinOne.dirIn : portBPinThree.dirIn;
    pinLatch[1] = unitTwoPinRoute ? portCPinOne.ioLatch
      : portBPinThree.ioLatch;
  end

  // pad level is synchronised whatever the direction, so port writes count
  always_ff @(posedge mclk) begin
    if (srst) begin
      syncA_ff <= 2'h0;
      syncB_ff <= 2'h0;
      prev_ff <= 2'h0;
    end else begin
      syncA_ff <= pinLevel;
      syncB_ff <= syncA_ff;
      prev_ff <= syncB_ff;
    end
  end
  assign riseEdge = syncB_ff & ~prev_ff;
  assign fallEdge = ~syncB_ff & prev_ff;

  // capture event per mode
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      unique case (ctrl_ff[u].mode)
        `CCU_MODE_CAP_FALL: capEvent[u] = fallEdge[u];
        `CCU_MODE_CAP_RISE: capEvent[u] = riseEdge[u];
        `CCU_MODE_CAP_4: capEvent[u] = riseEdge[u] &&
          ps_ff[u][1:0] == `CCU_PS4_LAST;
        `CCU_MODE_CAP_16: capEvent[u] = riseEdge[u] &&
          ps_ff[u] == `CCU_PS16_LAST;
        default: capEvent[u] = 1'b0;
      endcase
    end
  end

  // prescaler survives a switch between capture codes, cleared otherwise
  always_ff @(posedge mclk) begin
    for (int u = 0; u < 2; u++) begin
      if (srst || !isCapture(ctrl_ff[u].mode)) begin
        ps_ff[u] <= `CCU_PS_RST;
      end else if (riseEdge[u]) begin
        ps_ff[u] <= ps_ff[u] + 4'h1;
      end
    end
  end

  // data register: capture overwrites, else byte writes from software
  always_ff @(posedge mclk) begin
    for (int u = 0; u < 2; u++) begin
      if (srst) begin
        data_ff[u] <= `CCU_DATA_RST;
      end else if (capEvent[u]) begin
        data_ff[u] <= timebase[u];
      end else begin
        if (dloWr[u]) begin
          data_ff[u][7:0] <= hwdata[7:0];
        end
        if (dhiWr[u]) begin
          data_ff[u][15:8] <= hwdata[7:0];
        end
      end
    end
  end

  // one flag event per match, so a stalled timer does not retrigger
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      matchEdge[u] = isCompare(ctrl_ff[u].mode) &&
        data_ff[u] == timebase[u] && !matchPrev_ff[u];
      seReq[u] = matchEdge[u] &&
        ctrl_ff[u].mode == `CCU_MODE_SPECIAL;
    end
  end

  always_ff @(posedge mclk) begin
    for (int u = 0; u < 2; u++) begin
      if (srst || ctrl_ff[u].mode == `CCU_MODE_OFF) begin
        matchPrev_ff[u] <= 1'b0;
      end else begin
        matchPrev_ff[u] <= data_ff[u] == timebase[u];
      end
    end
  end

  // flags: hardware set wins over a write-one-to-clear
  always_ff @(posedge mclk) begin
    for (int u = 0; u < 2; u++) begin
      if (srst) begin
        flag_ff[u] <= 1'b0;
      end else if (capEvent[u] || matchEdge[u]) begin
        flag_ff[u] <= 1'b1;
      end else if (flagWr && hwdata[u]) begin
        flag_ff[u] <= 1'b0;
      end
    end
  end

  // compare output latch; mode writes set its starting level
  always_ff @(posedge mclk) begin
    for (int u = 0; u < 2; u++) begin
      if (srst) begin
        cmpLatch_ff[u] <= 1'b0;
      end else if (ctrlWr[u]) begin
        unique case (hwdata[3:0])
          `CCU_MODE_OFF: cmpLatch_ff[u] <= 1'b0;
          `CCU_MODE_SET_HI: cmpLatch_ff[u] <= 1'b0;
          `CCU_MODE_SET_LO: cmpLatch_ff[u] <= 1'b1;
          default: cmpLatch_ff[u] <= cmpLatch_ff[u];
        endcase
      end else if (matchEdge[u]) begin
        unique case (ctrl_ff[u].mode)
          `CCU_MODE_TOGGLE: cmpLatch_ff[u] <= ~cmpLatch_ff[u];
          `CCU_MODE_SET_HI: cmpLatch_ff[u] <= 1'b1;
          `CCU_MODE_SET_LO: cmpLatch_ff[u] <= 1'b0;
          default: cmpLatch_ff[u] <= cmpLatch_ff[u];
        endcase
      end
    end
  end

  // special event pulses toward the assigned timer, and from unit two only toward the converter
  always_ff @(posedge mclk) begin
    if (srst) begin
      resetFirst_ff <= 1'b0;
      resetThird_ff <= 1'b0;
      adStart_ff <= 1'b0;
    end else begin
      resetFirst_ff <= |(seReq & ~useThird);
      resetThird_ff <= |(seReq & useThird);
      adStart_ff <= seReq[1];
    end
  end
  // a timer write in the same cycle masks the reset
  assign resetFirstTimer = resetFirst_ff & ~firstTimerWrite;
  assign resetThirdTimer = resetThird_ff & ~thirdTimerWrite;
  assign adStart = adStart_ff;

  // pwm status: both units report active and a 10-bit duty, data low byte over the duty bits
  always_ff @(posedge mclk) begin
    for (int u = 0; u < 2; u++) begin
      if (srst) begin
        pwmActive_ff[u] <= 1'b0;
        pwmDuty_ff[u] <= 10'h000;
      end else begin
        pwmActive_ff[u] <= isPwm(ctrl_ff[u].mode);
        pwmDuty_ff[u] <= isPwm(ctrl_ff[u].mode) ?
          {data_ff[u][7:0], ctrl_ff[u].duty} : 10'h000;
      end
    end
  end
  assign pwmActive = pwmActive_ff;
  assign pwmDuty = pwmDuty_ff;
  assign unitInterruptFlag = flag_ff;
  assign unitInterruptEnable = ien_ff;

  // pad drive; direction bit still decides the enable
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      unitDrives[u] = isCompare(ctrl_ff[u].mode) &&
        ctrl_ff[u].mode != `CCU_MODE_SWINT;
      padOut[u] = unitDrives[u] ? cmpLatch_ff[u] : pinLatch[u];
    end
  end
  assign unitOnePinOut = '{drive: padOut[0], oe: ~pinDir[0]};
  assign portCPinOneOut = unitTwoPinRoute ?
    '{drive: padOut[1], oe: ~pinDir[1]} : '{drive: 1'b0, oe: 1'b0};
  assign portBPinThreeOut = unitTwoPinRoute ?
    '{drive: 1'b0, oe: 1'b0} : '{drive: padOut[1], oe: ~pinDir[1]};

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  ps_clear_a: assert property (
    !isCapture(ctrl_ff[0].mode) |=> ps_ff[0] == `CCU_PS_RST)
    else $error("prescaler not cleared outside capture");
  flag_set_a: assert property (
    capEvent[1] |=> flag_ff[1])
    else $error("capture did not set flag");
  cap_load_a: assert property (
    capEvent[0] |=> data_ff[0] == $past(timebase[0]))
    else $error("capture value wrong");
  fall_cap_a: assert property (
    ctrl_ff[0].mode == `CCU_MODE_CAP_FALL && $fell(syncB_ff[0])
    |-> capEvent[0])
    else $error("falling edge not captured");
  ps_four_a: assert property (
    ctrl_ff[0].mode == `CCU_MODE_CAP_4 && capEvent[0]
    |-> ps_ff[0][1:0] == `CCU_PS4_LAST && riseEdge[0])
    else $error("divide by four capture early");
  off_latch_a: assert property (
    ctrl_ff[0].mode == `CCU_MODE_OFF && !ctrlWr[0] |=> !cmpLatch_ff[0])
    else $error("latch not low while off");
  toggle_pin_a: assert property (
    ctrl_ff[0].mode == `CCU_MODE_TOGGLE && matchEdge[0] && !ctrlWr[0]
    |=> cmpLatch_ff[0] != $past(cmpLatch_ff[0]))
    else $error("toggle missed");
  ad_start_a: assert property (
    seReq[1] |=> adStart_ff ##1 !adStart_ff || seReq[1])
    else $error("converter start not pulsed");
  write_wins_a: assert property (
    firstTimerWrite |-> !resetFirstTimer)
    else $error("reset beat timer write");
  route_pin_a: assert property (
    unitTwoPinRoute |-> !portBPinThreeOut.oe)
    else $error("unit two drives unrouted pin");

endmodule
`default_nettype wire

// ### ccu_pad_model.sv
// far-side model: pad levels seen by the units and the two time bases
`timescale 1ns/1ps
`default_nettype none
module ccu_pad_model import ccu_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // outside pad levels, direction bits, port latches
  input wire logic [2:0] extLevel,
  input wire logic [2:0] padDirIn,
  input wire logic [2:0] padLatch,
  // pad traffic to and from the units
  input wire ccu_pin_out_t [2:0] padOut,
  output var ccu_pin_in_t [2:0] padIn,
  // timer control from the bench and the units
  input wire logic tmrRun,
  input wire logic [15:0] tmrLoad,
  input wire logic firstTimerWrite,
  input wire logic thirdTimerWrite,
  input wire logic resetFirstTimer,
  input wire logic resetThirdTimer,
  // timer counts
  output logic [15:0] firstTimerCount,
  output logic [15:0] thirdTimerCount
);
  // a pad the unit drives shows that drive, so port writes reach capture
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      padIn[i].level = padOut[i].oe ? padOut[i].drive : extLevel[i];
      padIn[i].dirIn = padDirIn[i];
      padIn[i].ioLatch = padLatch[i];
    end
  end
  // both timers count on mclk only: no asynchronous counter mode here
  always_ff @(posedge mclk) begin
    if (srst) begin
      firstTimerCount <= 16'h0000;
      thirdTimerCount <= 16'h0000;
    end else begin
      // a software load beats a special-event clear in the same cycle
      if (firstTimerWrite) firstTimerCount <= tmrLoad;
      else if (resetFirstTimer) firstTimerCount <= 16'h0000;
      else if (tmrRun) firstTimerCount <= firstTimerCount + 16'h0001;
      if (thirdTimerWrite) thirdTimerCount <= ~tmrLoad;
      else if (resetThirdTimer) thirdTimerCount <= 16'h0000;
      else if (tmrRun) thirdTimerCount <= thirdTimerCount + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ### ccu_testbench.sv
// bench: registers, capture, prescaler and compare over ahb-lite
`timescale 1ns/1ps
`default_nettype none
`include "ccu_params.svh"
module testbench import ccu_pkg::*;;
  logic mclk, srst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, flagOut, ienOut, pwmActive;
  logic [2:0] hsize, extLevel, padDirIn, padLatch;
  logic [15:0] tmrLoad;
  wire logic [15:0] firstCnt, thirdCnt;
  logic firstWr, thirdWr, rstFirst, rstThird, adStart, tmrRun, route;
  wire ccu_pin_in_t [2:0] padIn;
  wire ccu_pin_out_t [2:0] padOut;
  logic [1:0][9:0] pwmDuty;
  logic [7:0] b;
  int n_fail, checks, nRst, nRst3, nAd, p;
  // compare table: unit, mode, pad drive on entry and after the match
  int uTab [6] = '{0, 0, 0, 0, 0, 1};
  logic [3:0] mTab [6] = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB, 4'hB};
  logic iTab [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic aTab [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  // the single slave never waits, its hreadyout is the bus hready
  assign hready = hreadyout;

  ccu_capture_compare_unit dut_u (
    .mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .firstTimerCount(firstCnt), .thirdTimerCount(thirdCnt),
    .firstTimerWrite(firstWr), .thirdTimerWrite(thirdWr),
    .resetFirstTimer(rstFirst), .resetThirdTimer(rstThird),
    .adStart(adStart), .unitOnePin(padIn[0]), .portCPinOne(padIn[1]),
    .portBPinThree(padIn[2]), .unitTwoPinRoute(route),
    .unitOnePinOut(padOut[0]), .portCPinOneOut(padOut[1]),
    .portBPinThreeOut(padOut[2]), .unitInterruptFlag(flagOut),
    .unitInterruptEnable(ienOut), .pwmActive(pwmActive), .pwmDuty(pwmDuty)
  );

  ccu_pad_model pad_u (
    .mclk(mclk), .srst(srst), .extLevel(extLevel), .padDirIn(padDirIn),
    .padLatch(padLatch), .padOut(padOut), .padIn(padIn), .tmrRun(tmrRun),
    .tmrLoad(tmrLoad), .firstTimerWrite(firstWr),
    .thirdTimerWrite(thirdWr), .resetFirstTimer(rstFirst),
    .resetThirdTimer(rstThird), .firstTimerCount(firstCnt),
    .thirdTimerCount(thirdCnt)
  );

  task automatic report_and_stop();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one single transfer; address held until hready, data until hready
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(nm, e, q);
  endtask

  // one-cycle software load of both timers (third gets the inverse)
  task automatic tload(input logic [15:0] v);
    tmrLoad <= v;
    firstWr <= 1'b1;
    thirdWr <= 1'b1;
    @(posedge mclk);
    firstWr <= 1'b0;
    thirdWr <= 1'b0;
    @(posedge mclk);
  endtask

  // pad level change, then the sync, detect and capture latency
  task automatic pad(input int i, input logic v);
    extLevel[i] <= v;
    repeat (6) @(posedge mclk);
  endtask

  task automatic rises(input int n);
    repeat (n) begin
      pad(0, 1'b1);
      pad(0, 1'b0);
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // counts of the one-cycle special-event pulses
  always @(posedge mclk) begin
    if (rstFirst === 1'b1) nRst++;
    if (rstThird === 1'b1) nRst3++;
    if (adStart === 1'b1) nAd++;
  end

  // the whole run needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    {hsel, hwrite, htrans, firstWr, thirdWr, tmrRun} = 7'h00;
    {haddr, hwdata} = 64'h0;
    // word transfers, pads low and all inputs, port latches low
    {hsize, extLevel, padDirIn, padLatch} = 12'h438;
    tmrLoad = 16'h0000;
    route = 1'b1;
    srst = 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    // reset values, the last address is unmapped
    for (int a = 0; a < 10; a++) rdchk("reset", 8'(a * 4), 32'h0);
    wr(`CCU_OFS_CTRL1, 32'hFC);
    rdchk("ctrl", `CCU_OFS_CTRL1, 32'h3C);
    wr(`CCU_OFS_DLO1, 32'hA5);
    wr(`CCU_OFS_DHI1, 32'h5A);
    wr(`CCU_OFS_IEN, 32'h2);
    rdchk("data high", `CCU_OFS_DHI1, 32'h5A);
    chk("ien", 32'h2, ienOut);
    chk("okay", 32'h0, hresp);
    chk("pwm active", 32'h1, pwmActive);
    chk("pwm duty", 32'h297, pwmDuty[0]);
    wr(`CCU_OFS_CTRL1, 32'h30);
    // duty register follows one edge after the mode write
    repeat (2) @(posedge mclk);
    chk("duty off", 32'h0, pwmDuty[0]);
    // two captures without a read: the second overwrites
    wr(`CCU_OFS_CTRL1, 32'h5);
    tload(16'h1234);
    pad(0, 1'b1);
    wr(`CCU_OFS_ASSIGN, 32'h2);
    tload(16'h0F0E);
    pad(0, 1'b0);
    pad(0, 1'b1);
    rdchk("cap lo", `CCU_OFS_DLO1, 32'hF1);
    rdchk("cap hi", `CCU_OFS_DHI1, 32'hF0);
    rdchk("flag kept", `CCU_OFS_FLAGS, 32'h1);
    wr(`CCU_OFS_FLAGS, 32'h1);
    rdchk("flag clr", `CCU_OFS_FLAGS, 32'h0);
    // split timers, falling edge on unit one, routed pads on unit two
    pad(0, 1'b0);
    wr(`CCU_OFS_ASSIGN, 32'h1);
    wr(`CCU_OFS_CTRL1, 32'h4);
    wr(`CCU_OFS_CTRL2, 32'h5);
    wr(`CCU_OFS_FLAGS, 32'h3);
    pad(0, 1'b1);
    rdchk("rise ignored", `CCU_OFS_FLAGS, 32'h0);
    pad(0, 1'b0);
    rdchk("fall cap", `CCU_OFS_DLO1, 32'h0E);
    pad(1, 1'b1);
    rdchk("unit2 cap", `CCU_OFS_DLO2, 32'hF1);
    route <= 1'b0;
    tload(16'h2222);
    pad(1, 1'b0);
    pad(1, 1'b1);
    rdchk("unrouted", `CCU_OFS_DLO2, 32'hF1);
    pad(2, 1'b1);
    rdchk("routed B", `CCU_OFS_DLO2, 32'hDD);
    // disabled unit ignores edges
    wr(`CCU_OFS_CTRL1, 32'h0);
    wr(`CCU_OFS_FLAGS, 32'h3);
    rises(1);
    rdchk("off", `CCU_OFS_FLAGS, 32'h0);
    // prescalers: clean /4, direct switch keeps count, off clears it
    wr(`CCU_OFS_CTRL1, 32'h6);
    rises(3);
    rdchk("ps4 early", `CCU_OFS_FLAGS, 32'h0);
    rises(1);
    rdchk("ps4", `CCU_OFS_FLAGS, 32'h1);
    wr(`CCU_OFS_CTRL1, 32'h0);
    wr(`CCU_OFS_CTRL1, 32'h6);
    rises(2);
    wr(`CCU_OFS_CTRL1, 32'h7);
    wr(`CCU_OFS_FLAGS, 32'h3);
    rises(13);
    rdchk("kept early", `CCU_OFS_FLAGS, 32'h0);
    rises(1);
    rdchk("kept count", `CCU_OFS_FLAGS, 32'h1);
    chk("flag out", 32'h1, flagOut);
    rises(2);
    wr(`CCU_OFS_CTRL1, 32'h0);
    wr(`CCU_OFS_CTRL1, 32'h7);
    wr(`CCU_OFS_FLAGS, 32'h3);
    rises(15);
    rdchk("ps16 early", `CCU_OFS_FLAGS, 32'h0);
    rises(1);
    rdchk("ps16", `CCU_OFS_FLAGS, 32'h1);
    // pad as an output: a port latch write makes the capture edge
    wr(`CCU_OFS_CTRL1, 32'h5);
    wr(`CCU_OFS_FLAGS, 32'h3);
    padDirIn[0] <= 1'b0;
    repeat (6) @(posedge mclk);
    padLatch[0] <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("pad oe", 32'h1, padOut[0].oe);
    rdchk("port write cap", `CCU_OFS_FLAGS, 32'h1);
    // compare modes, first timer frozen at zero and third at FFFF until the run starts
    for (int i = 0; i < 6; i++) begin
      b = uTab[i] ? `CCU_OFS_STEP : 8'h00;
      p = uTab[i] * 2;
      // unit two runs on the third timer through the split assignment
      wr(`CCU_OFS_ASSIGN, {31'h0, uTab[i] == 1});
      wr(b, 32'h0);
      tload(16'h0000);
      wr(b + 8'h04, 32'h20);
      wr(b + 8'h08, 32'h0);
      wr(`CCU_OFS_FLAGS, 32'h3);
      wr(b, {28'h0, mTab[i]});
      @(posedge mclk);
      chk("entry drive", iTab[i], padOut[p].drive);
      nRst = 0;
      nAd = 0;
      nRst3 = 0;
      tmrRun <= 1'b1;
      repeat (48) @(posedge mclk);
      tmrRun <= 1'b0;
      @(posedge mclk);
      chk("match drive", aTab[i], padOut[p].drive);
      rdchk("cmp flag", `CCU_OFS_FLAGS, 32'h1 << uTab[i]);
      chk("tmr reset", {31'h0, mTab[i] == 4'hB && uTab[i] == 0}, nRst);
      chk("third_timer reset", {31'h0, mTab[i] == 4'hB && uTab[i] == 1},
          nRst3);
      chk("ad start", {31'h0, mTab[i] == 4'hB && uTab[i] == 1}, nAd);
      wr(b, 32'h0);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
